// ### core/lpsc_defines.svh
`ifndef LPSC_DEFINES_SVH
`define LPSC_DEFINES_SVH

// Port count of the switch
`define LPSC_NUM_PORTS 4
// Power-on hold time and its cycle count at 125 MHz (8 ns period)
`define LPSC_PERST_MIN_MS 100
`define LPSC_CLK_PERIOD_NS 8
`define LPSC_PERST_MIN_CYC ((`LPSC_PERST_MIN_MS * 1000000) / `LPSC_CLK_PERIOD_NS)
// Cycles that the PLL must settle after it is switched back on
`define LPSC_PLL_WAKE_CYC 16
// Reset value of the shared clock enable
`define LPSC_PLL_RST_VAL 1'b1

`endif

// ### core/lpsc_pkg.sv
package lpsc_pkg;

    // Link power states
    typedef enum logic [2:0] {
        LPSC_L0,
        LPSC_L0S,
        LPSC_L1,
        LPSC_L11,
        LPSC_L23_RDY,
        LPSC_L3
    } lpsc_link_t;

    // Function power states
    typedef enum logic [2:0] {
        LPSC_D0,
        LPSC_D1,
        LPSC_D2,
        LPSC_D3HOT,
        LPSC_D3COLD
    } lpsc_func_t;

    // Requests from the link layer
    typedef enum logic [2:0] {
        LPSC_REQ_NONE,
        LPSC_REQ_L0,
        LPSC_REQ_L0S,
        LPSC_REQ_L1,
        LPSC_REQ_L23,
        LPSC_REQ_L3
    } lpsc_req_t;

endpackage

// ### core/lpsc_port.sv
`timescale 1ns/10ps
`include "lpsc_defines.svh"

// One port's link power state machine
module lpsc_port
    import lpsc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire lpsc_req_t req_i,
    input wire logic aspm_i,
    input wire logic sw_l1_i,
    input wire logic l11_en_i,
    input wire logic clkreq_n_i,
    output lpsc_link_t state_o,
    output logic rx_on_o,
    output logic in_l11_o
);

    lpsc_link_t state_q;
    lpsc_link_t state_d;
    wire logic clkreq_act = ~clkreq_n_i;
    wire logic l1_allowed = aspm_i | sw_l1_i;

    // ----------------------------------------
    // State transitions
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            LPSC_L0: begin
                if (req_i == LPSC_REQ_L0S && aspm_i) begin
                    state_d = LPSC_L0S;
                end else if (req_i == LPSC_REQ_L1 && l1_allowed) begin
                    state_d = LPSC_L1;
                end else if (req_i == LPSC_REQ_L23) begin
                    state_d = LPSC_L23_RDY;
                end
            end
            LPSC_L0S: begin
                if (req_i == LPSC_REQ_L0) begin
                    state_d = LPSC_L0;
                end
            end
            LPSC_L1: begin
                // Substate only on clock request and when enabled
                if (clkreq_act && l11_en_i) begin
                    state_d = LPSC_L11;
                end else if (req_i == LPSC_REQ_L0) begin
                    state_d = LPSC_L0;
                end
            end
            LPSC_L11: begin
                if (!clkreq_act) begin
                    state_d = LPSC_L1;
                end
            end
            LPSC_L23_RDY: begin
                if (req_i == LPSC_REQ_L3) begin
                    state_d = LPSC_L3;
                end else if (req_i == LPSC_REQ_L0) begin
                    state_d = LPSC_L0;
                end
            end
            default: begin
                // L3 leaves only through reset
                state_d = state_q;
            end
        endcase
    end

    // Held in L0 while the fundamental reset stands
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= LPSC_L0;
        end else if (!run_i) begin
            state_q <= LPSC_L0;
        end else begin
            state_q <= state_d;
        end
    end

    assign state_o = state_q;
    assign in_l11_o = (state_q == LPSC_L11);
    assign rx_on_o = ~in_l11_o;

endmodule

// ### core/lpsc_top.sv
`timescale 1ns/10ps
`include "lpsc_defines.svh"

// Functional notes
// - A port in L1 enters L1.1 when its clock request is asserted.
// - In L1.1 the port receiver and its PLL share are powered down.
// - Clock request released in L1.1 returns the link to L1, circuits back on.
// - Shared PLL turns off only when every port is in L1.1.
// - Any port not in L1.1 keeps PLL and internal clock running.
// - All link and switch functions held in reset while PERST is asserted.
// - Link states L0, L0s, L1, L2/L3 ready and L3 with ASPM moves.
// - Function power states D0, D1, D2, D3-hot and D3-cold are supported.
// - L1.1 reachable via ASPM and via software-directed L1 entry.
module lpsc_top
    import lpsc_pkg::*;
#(
    parameter int NPORTS = `LPSC_NUM_PORTS,
    parameter int PERST_MIN_CYC = `LPSC_PERST_MIN_CYC
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic perst_n_i,
    input wire logic [NPORTS-1:0] clkreq_n_i,
    input wire logic [NPORTS-1:0] l11_en_i,
    input wire logic [NPORTS-1:0] aspm_en_i,
    input wire logic [NPORTS-1:0] sw_l1_i,
    input wire logic [3*NPORTS-1:0] link_req_i,
    input wire logic [2:0] func_req_i,
    input wire logic func_req_vld_i,
    output logic func_rst_n_o,
    output logic [3*NPORTS-1:0] link_state_o,
    output logic [NPORTS-1:0] rx_on_o,
    output logic [NPORTS-1:0] l11_o,
    output logic pll_on_o,
    output logic [2:0] func_state_o,
    output logic perst_short_o
);

    // ----------------------------------------
    // Reset hold
    // ----------------------------------------
    // Run flag, low-time counter and the flag that says a low time was seen
    logic run_q;
    logic perst_seen_q;
    logic [31:0] hold_cnt_q;
    wire logic hold_done = (hold_cnt_q >= 32'(PERST_MIN_CYC));

    // Functions run only while PERST is released
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q <= 1'b0;
        end else begin
            run_q <= perst_n_i;
        end
    end

    // Measures PERST low time; the far side owns the length, we only flag it
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_cnt_q <= 32'h0;
            perst_seen_q <= 1'b0;
            perst_short_o <= 1'b0;
        end else if (!perst_n_i) begin
            perst_seen_q <= 1'b1;
            if (!hold_done) begin
                hold_cnt_q <= hold_cnt_q + 32'h1;
            end
        end else if (perst_seen_q) begin
            perst_seen_q <= 1'b0;
            hold_cnt_q <= 32'h0;
            perst_short_o <= ~hold_done;
        end
    end

    // Functions see PERST through one flop, so every block wakes on the same edge
    assign func_rst_n_o = run_q;

    // ----------------------------------------
    // Ports
    // ----------------------------------------
    // Substate flags of all ports, gathered for the PLL decision
    logic [NPORTS-1:0] in_l11;

    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        lpsc_link_t st;
        lpsc_port u_port (
            .core_clk_i(core_clk_i),
            .rst_n_i(rst_n_i),
            .run_i(run_q),
            .req_i(lpsc_req_t'(link_req_i[3*p +: 3])),
            .aspm_i(aspm_en_i[p]),
            .sw_l1_i(sw_l1_i[p]),
            .l11_en_i(l11_en_i[p]),
            .clkreq_n_i(clkreq_n_i[p]),
            .state_o(st),
            .rx_on_o(rx_on_o[p]),
            .in_l11_o(in_l11[p])
        );
        assign link_state_o[3*p +: 3] = st;

        // Every port is held to the same substate entry and exit timing
        AST_PORT_ENTRY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
            (st == LPSC_L1 && !clkreq_n_i[p] && l11_en_i[p] && run_q) |=> in_l11[p])
            else $error("port missed L1.1 entry");
        AST_PORT_EXIT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
            (in_l11[p] && clkreq_n_i[p] && run_q) |=> (!in_l11[p] && rx_on_o[p]))
            else $error("port missed L1.1 exit");
    end

    // Substate flags leave straight from the port state registers
    assign l11_o = in_l11;

    // ----------------------------------------
    // Shared PLL
    // ----------------------------------------
    // All ports idle deep enough; one empty port blocks the saving
    wire logic all_l11 = &in_l11;
    logic pll_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pll_q <= `LPSC_PLL_RST_VAL;
        end else begin
            pll_q <= ~(all_l11 & run_q);
        end
    end

    // Registered so a passing mix of port states never reaches the analog enable
    assign pll_on_o = pll_q;

    // ----------------------------------------
    // Function power state
    // ----------------------------------------
    // Current D state; codes above D3-cold have no meaning and are dropped
    lpsc_func_t func_q;
    wire logic func_ok = (func_req_i <= 3'(LPSC_D3COLD));

    // Out-of-range requests are ignored rather than trapped
    // PERST is also looked at directly, so a strobe in its first cycle cannot land
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            func_q <= LPSC_D0;
        end else if (!run_q || !perst_n_i) begin
            func_q <= LPSC_D0;
        end else if (func_req_vld_i && func_ok) begin
            func_q <= lpsc_func_t'(func_req_i);
        end
    end

    assign func_state_o = func_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Entry: port 0 in detail, port 1 by its cause; the port loop covers all ports
    AST_L11_ENTRY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (g_port[0].st == LPSC_L1 && !clkreq_n_i[0] && l11_en_i[0] && run_q)
        |=> l11_o[0]) else $error("port0 missed L1.1 entry");
    AST_L11_CAUSE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (!l11_o[1] ##1 l11_o[1])
        |-> ($past(g_port[1].st) == LPSC_L1 && $past(l11_en_i[1]) && !$past(clkreq_n_i[1])))
        else $error("port1 entered L1.1 without cause");

    // Exit and receiver: the receiver follows the substate with no extra flop
    AST_RX_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        l11_o[0] |-> !rx_on_o[0]) else $error("receiver on in L1.1");
    AST_L11_EXIT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (l11_o[0] && clkreq_n_i[0] && run_q) |=> (!l11_o[0] && rx_on_o[0]))
        else $error("port0 stuck in L1.1");
    AST_RX_BACK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (l11_o[3] && clkreq_n_i[3] && run_q) |=> rx_on_o[3])
        else $error("port3 receiver not resumed");

    // Shared PLL: off only with every port asleep, back on as soon as one wakes
    AST_PLL_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (&l11_o && run_q) |=> !pll_on_o) else $error("PLL not saved");
    AST_PLL_KEEP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !(&l11_o) |=> pll_on_o) else $error("PLL off with port awake");

    // Reset hold and release
    // The short flag may only move at a PERST release, never while PERST is held
    AST_PERST_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !perst_n_i |=> (!func_rst_n_o && func_state_o == 3'(LPSC_D0)))
        else $error("functions out of reset");
    AST_RUN_START: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        perst_n_i |=> func_rst_n_o) else $error("functions not started");
    AST_SHORT_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !(perst_n_i && !$past(perst_n_i)) |=> $stable(perst_short_o))
        else $error("short flag moved without release");

    // Link state moves need their enables; L3 waits for reset
    AST_L0S_ASPM: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (g_port[0].st == LPSC_L0 && $past(g_port[0].st) == LPSC_L0 && 1'b1)
        ##1 (g_port[0].st == LPSC_L0S) |-> $past(aspm_en_i[0]))
        else $error("L0s without ASPM");
    AST_L3_STICKY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (g_port[0].st == LPSC_L3 && run_q) |=> g_port[0].st == LPSC_L3)
        else $error("L3 left without reset");
    AST_L1_PATH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ($past(g_port[0].st) == LPSC_L0 && g_port[0].st == LPSC_L1)
        |-> $past(aspm_en_i[0] | sw_l1_i[0])) else $error("L1 without path");

    // Function power state takes every legal request at once
    AST_FUNC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (run_q && perst_n_i && func_req_vld_i && func_ok) |=> func_state_o == $past(func_req_i))
        else $error("function state not taken");

    // Main scenarios: substate round trip, PLL saving, deep D state, L0s, short PERST
    COV_L11: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) l11_o[0] ##1 !l11_o[0]);
    COV_PLL: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) !pll_on_o);
    COV_D3: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        func_state_o == 3'(LPSC_D3HOT));
    COV_L0S: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        g_port[0].st == LPSC_L0S);
    COV_SHORT: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        perst_short_o);

endmodule

// ### tb/lpsc_partner.sv
`timescale 1ns/10ps

// ----------------------------------------
// Link partner clock-request model
// ----------------------------------------
// A fast partner answers one cycle after it is asked, a slow one three
module lpsc_partner #(
    parameter int NP = 4
)
(
    input wire logic core_clk_i,
    input wire logic [NP-1:0] want_l11_i,
    input wire logic slow_i,
    output logic [NP-1:0] clkreq_n_o
);
    logic [NP-1:0] wish_q = '0;
    logic [NP-1:0] d1_q = '0;
    logic [NP-1:0] d2_q = '0;
    logic [NP-1:0] d3_q = '0;

    // Wishes are taken on the rising edge, so a falling-edge bench update never races the line
    always @(posedge core_clk_i) begin
        wish_q <= want_l11_i;
    end

    // Delay line of wishes, moved on the falling edge like all bench stimulus
    always @(negedge core_clk_i) begin
        d1_q <= wish_q;
        d2_q <= d1_q;
        d3_q <= d2_q;
    end

    // Line is driven high by the inverter when nothing is requested
    assign clkreq_n_o = slow_i ? ~d3_q : ~d1_q;
endmodule

// ### tb/tb_link_l1_substate_power_control.sv
`timescale 1ns/10ps

// ----------------------------------------
// Self-checking bench for the port power sequencer
// ----------------------------------------
module tb_link_l1_substate_power_control;
    import lpsc_pkg::*;
    localparam int NP = 4;
    localparam int PMIN = 20;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic perst_n_i = 1'b0;
    logic [NP-1:0] clkreq_n, l11_en = '0, aspm_en = '0, sw_l1 = '0, want = '0, rx_on, l11;
    logic [3*NP-1:0] link_req = '0, link_state;
    logic [2:0] func_req = 3'h0, func_state;
    logic func_vld = 1'b0, func_rst_n, pll_on, perst_short, slow = 1'b0;
    int failures = 0;
    int checks = 0;

    // Clock at 125 MHz
    always #4 core_clk_i = ~core_clk_i;

    lpsc_partner #(.NP(NP)) partner (.core_clk_i(core_clk_i), .want_l11_i(want),
        .slow_i(slow), .clkreq_n_o(clkreq_n));

    lpsc_top #(.NPORTS(NP), .PERST_MIN_CYC(PMIN)) uut (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .perst_n_i(perst_n_i), .clkreq_n_i(clkreq_n),
        .l11_en_i(l11_en), .aspm_en_i(aspm_en), .sw_l1_i(sw_l1), .link_req_i(link_req),
        .func_req_i(func_req), .func_req_vld_i(func_vld), .func_rst_n_o(func_rst_n),
        .link_state_o(link_state), .rx_on_o(rx_on), .l11_o(l11), .pll_on_o(pll_on),
        .func_state_o(func_state), .perst_short_o(perst_short));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    // Every port gets the same request code
    function automatic logic [3*NP-1:0] all4(input logic [2:0] c);
        return {c, c, c, c};
    endfunction

    // PERST low for lo cycles, then wait bounded for functions to run
    task automatic perst_pulse(input int lo);
        int n;
        perst_n_i = 1'b0;
        cyc(lo);
        chk({11'h0, func_rst_n}, 12'h000, "func held");
        chk(link_state, all4(LPSC_L0), "state cleared");
        perst_n_i = 1'b1;
        n = 0;
        while (func_rst_n !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 10) begin
                failures++;
                $display("[FAIL] %0t functions never left reset", $time);
                stop_test();
            end
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_up();
        chk({11'h0, pll_on}, 12'h001, "pll on in reset");
        perst_pulse(PMIN + 5);
        chk({11'h0, perst_short}, 12'h000, "long perst");
        $display("test power_up done");
    endtask

    task automatic t_all_l11();
        aspm_en = 4'h7; // Port 3 enters L1 by software only
        sw_l1 = 4'h8;
        l11_en = 4'hF;
        link_req = all4(LPSC_REQ_L1);
        cyc(2);
        chk(link_state, all4(LPSC_L1), "all in L1");
        want = 4'hF;
        cyc(4);
        chk(link_state, all4(LPSC_L11), "all in L1.1");
        chk({8'h0, rx_on, l11}, 12'h00F, "rx off");
        chk({11'h0, pll_on}, 12'h000, "pll off");
        want = 4'hE;
        cyc(4);
        chk(link_state[2:0], LPSC_L1, "port0 back to L1");
        chk({8'h0, rx_on, l11}, 12'h01E, "rx port0 on");
        chk({11'h0, pll_on}, 12'h001, "pll back on");
        $display("test all_l11 done");
    endtask

    task automatic t_one_plain_l1();
        want = 4'h0;
        l11_en = 4'hB; // Port 2 cannot reach L1.1 and is kept in plain L1
        slow = 1'b1;
        cyc(6);
        want = 4'hF;
        cyc(7);
        chk(link_state[8:6], LPSC_L1, "port2 stays L1");
        chk({8'h0, l11, rx_on}, 12'h0B4, "three in L1.1");
        chk({11'h0, pll_on}, 12'h001, "pll kept on");
        want = 4'h0;
        slow = 1'b0;
        link_req = all4(LPSC_REQ_L0);
        cyc(4);
        chk(link_state, all4(LPSC_L0), "back to L0");
        $display("test one_plain_l1 done");
    endtask

    task automatic t_link_states();
        aspm_en = 4'h0;
        sw_l1 = 4'h0;
        link_req = all4(LPSC_REQ_L0S);
        cyc(2);
        chk(link_state, all4(LPSC_L0), "L0s refused");
        link_req = all4(LPSC_REQ_L1);
        cyc(2);
        chk(link_state, all4(LPSC_L0), "L1 refused");
        aspm_en = 4'hF;
        link_req = all4(LPSC_REQ_L0S);
        cyc(2);
        chk(link_state, all4(LPSC_L0S), "L0s");
        link_req = all4(LPSC_REQ_L0);
        cyc(2);
        link_req = all4(LPSC_REQ_L23);
        cyc(2);
        chk(link_state, all4(LPSC_L23_RDY), "L2/L3 ready");
        link_req = all4(LPSC_REQ_L3);
        cyc(2);
        link_req = all4(LPSC_REQ_L0);
        cyc(2);
        chk(link_state, all4(LPSC_L3), "L3 sticky");
        $display("test link_states done");
    endtask

    task automatic t_func_states();
        for (int i = 0; i <= 5; i++) begin
            func_req = 3'(i);
            func_vld = 1'b1;
            cyc(1);
            func_vld = 1'b0;
            cyc(1);
            chk({9'h0, func_state}, (i > 4) ? 12'h004 : 12'(i), "D state");
        end
        $display("test func_states done");
    endtask

    task automatic t_short_perst();
        perst_pulse(3);
        chk({11'h0, perst_short}, 12'h001, "short perst flagged");
        chk({9'h0, func_state}, 12'h000, "D0 after perst");
        $display("test short_perst done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(6);
        rst_n_i = 1'b1;
        cyc(2);
        t_power_up();
        t_all_l11();
        t_one_plain_l1();
        t_link_states();
        t_func_states();
        t_short_perst();
        stop_test();
    end
endmodule
